// ==== hdl/ccs_ctrl.sv ====
// Configuration control and status handshake controller.
// Assumes pins are synchronous to clk_i and open-drain wires resolved outside.
`timescale 1ns/1ps
module ccs_ctrl
  import ccs_pkg::*;
#(
  parameter int unsigned POR_US = POR_TIME_US
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [SCHEME_W-1:0] scheme_select_i,
  input  wire logic                config_req_n_i,
  input  wire logic                chip_enable_n_i,
  input  wire logic                jtag_mode_i,
  input  wire logic                auto_restart_i,
  input  wire logic                data_done_i,
  input  wire logic                data_error_i,
  input  wire logic                init_done_i,
  input  wire logic                status_i,
  output logic                     status_o,
  output logic                     status_oe_n_o,
  input  wire logic                config_complete_i,
  output logic                     config_complete_o,
  output logic                     config_complete_oe_n_o,
  output logic [SCHEME_W-1:0]      scheme_o,
  output logic                     io_float_o,
  output logic                     configuring_o,
  output logic                     user_mode_o
);
  ccs_state_t state_q;
  ccs_state_t state_d;
  logic       req_hi;
  logic       may_start;
  logic       cfg_err;
  logic       tmr_done;

  ccs_tmr_if tif ();

  ccs_timer u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (tif)
  );

  // ----------------------------------------
  // Conditions
  // ----------------------------------------
  assign tmr_done  = tif.done;
  assign req_hi    = config_req_n_i || jtag_mode_i;
  assign may_start = req_hi && !chip_enable_n_i;
  // External low on status counts only while configuring or initialising
  assign cfg_err   = data_error_i || !status_i;

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      CCS_POR: begin
        if (tmr_done) begin
          state_d = may_start ? CCS_CONFIG : CCS_RESET;
        end
      end
      CCS_RESET: begin
        if (may_start) begin
          state_d = CCS_CONFIG;
        end
      end
      CCS_CONFIG: begin
        if (!req_hi) begin
          state_d = CCS_RESET;
        end else if (cfg_err) begin
          state_d = auto_restart_i ? CCS_PULSE : CCS_ERROR;
        end else if (data_done_i) begin
          state_d = CCS_INIT;
        end
      end
      CCS_INIT: begin
        if (!req_hi) begin
          state_d = CCS_RESET;
        end else if (cfg_err) begin
          state_d = auto_restart_i ? CCS_PULSE : CCS_ERROR;
        end else if (init_done_i) begin
          state_d = CCS_USER;
        end
      end
      CCS_USER: begin
        // Status pin deliberately not looked at here
        if (!req_hi) begin
          state_d = CCS_RESET;
        end
      end
      CCS_ERROR: begin
        if (!req_hi) begin
          state_d = CCS_RESET;
        end
      end
      CCS_PULSE: begin
        if (!req_hi) begin
          state_d = CCS_RESET;
        end else if (tmr_done) begin
          state_d = CCS_CONFIG;
        end
      end
      default: state_d = CCS_POR;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= CCS_POR;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------
  // Timer control
  // ----------------------------------------
  assign tif.start    = (state_d == CCS_PULSE) && (state_q != CCS_PULSE);
  assign tif.limit_us = (state_q == CCS_POR) ? US_W'(POR_US) : US_W'(PULSE_MIN_US);

  // ----------------------------------------
  // Scheme latch
  // ----------------------------------------
  // Sampled once per attempt, so a moving strap cannot change scheme midway
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scheme_o <= SCHEME_RST;
    end else if (state_d == CCS_CONFIG && state_q != CCS_CONFIG) begin
      scheme_o <= scheme_select_i;
    end
  end

  // ----------------------------------------
  // Pins
  // ----------------------------------------
  assign status_o          = 1'b0;
  assign config_complete_o = 1'b0;
  assign status_oe_n_o     = !(state_q == CCS_POR || state_q == CCS_RESET
                               || state_q == CCS_ERROR || state_q == CCS_PULSE);
  assign config_complete_oe_n_o = (state_q == CCS_INIT || state_q == CCS_USER);
  assign io_float_o        = (state_q != CCS_USER);
  assign configuring_o     = (state_q == CCS_CONFIG || state_q == CCS_INIT);
  assign user_mode_o       = (state_q == CCS_USER);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [15:0] low_len_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != CCS_PULSE) begin
      low_len_q <= 16'h0000;
    end else begin
      low_len_q <= low_len_q + 16'h0001;
    end
  end

  property p_scheme_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_CONFIG && $past(state_q) == CCS_CONFIG) |-> $stable(scheme_o);
  endproperty
  a_scheme_hold: assert property (p_scheme_hold) else $error("scheme changed mid attempt");

  property p_user_drop;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_USER && !config_req_n_i && !jtag_mode_i)
        |=> (state_q == CCS_RESET && io_float_o && !user_mode_o);
  endproperty
  a_user_drop: assert property (p_user_drop) else $error("request low not honoured");

  property p_restart;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_RESET && config_req_n_i && !chip_enable_n_i)
        |=> (configuring_o && scheme_o == $past(scheme_select_i));
  endproperty
  a_restart: assert property (p_restart) else $error("no attempt after request high");

  property p_jtag_ignore;
    @(posedge clk_i) disable iff (rst_i)
      (jtag_mode_i && state_q != CCS_RESET && state_q != CCS_POR) |=> (state_q != CCS_RESET);
  endproperty
  a_jtag_ignore: assert property (p_jtag_ignore) else $error("request obeyed in jtag");

  property p_por_hold;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_POR) |-> (!status_oe_n_o && configuring_o == 1'b0);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("status released in power-on");

  property p_open_drain;
    @(posedge clk_i) disable iff (rst_i)
      !status_oe_n_o |-> (status_o == 1'b0 && config_complete_o == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");

  property p_error_low;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_CONFIG && req_hi && data_error_i) |=> !status_oe_n_o;
  endproperty
  a_error_low: assert property (p_error_low) else $error("error not reported");

  property p_ext_error;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_INIT && req_hi && !status_i)
        |=> (state_q == CCS_ERROR || state_q == CCS_PULSE);
  endproperty
  a_ext_error: assert property (p_ext_error) else $error("external low missed");

  property p_user_ignore;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_USER && req_hi) |=> user_mode_o;
  endproperty
  a_user_ignore: assert property (p_user_ignore) else $error("left user mode");

  property p_pulse_len;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_PULSE && state_d == CCS_CONFIG)
        |-> (low_len_q >= 16'(PULSE_MIN_CYC - 1) && low_len_q < 16'(PULSE_MAX_CYC));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("error pulse width wrong");

  property p_pulse_retry;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_PULSE && tmr_done && req_hi) |=> (configuring_o && status_oe_n_o);
  endproperty
  a_pulse_retry: assert property (p_pulse_retry) else $error("no retry after pulse");

  property p_complete_line;
    @(posedge clk_i) disable iff (rst_i)
      (state_q == CCS_CONFIG && req_hi && !cfg_err && data_done_i)
        |=> (state_q == CCS_INIT && config_complete_oe_n_o);
  endproperty
  a_complete_line: assert property (p_complete_line) else $error("completion not released");

  c_user:  cover property (@(posedge clk_i) disable iff (rst_i) state_q == CCS_USER);
  c_pulse: cover property (@(posedge clk_i) disable iff (rst_i)
                           state_q == CCS_PULSE ##1 state_q == CCS_CONFIG);
  c_recfg: cover property (@(posedge clk_i) disable iff (rst_i)
                           state_q == CCS_USER ##1 state_q == CCS_RESET);
endmodule

// ==== hdl/ccs_pkg.sv ====
// Constants shared by the configuration control and status handshake.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package ccs_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned NS_PER_US      = 1000;
  localparam int unsigned CYC_PER_US     = NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned POR_TIME_US    = 100000;
  localparam int unsigned PULSE_MIN_US   = 10;
  localparam int unsigned PULSE_MAX_US   = 500;
  localparam int unsigned PULSE_MIN_CYC  = PULSE_MIN_US * CYC_PER_US;
  localparam int unsigned PULSE_MAX_CYC  = PULSE_MAX_US * CYC_PER_US;
  localparam int unsigned US_W           = 20;
  localparam int unsigned SCHEME_W       = 3;
  localparam logic [2:0]  SCHEME_RST     = 3'h0;

  typedef enum logic [6:0] {
    CCS_POR    = 7'h01,
    CCS_RESET  = 7'h02,
    CCS_CONFIG = 7'h04,
    CCS_INIT   = 7'h08,
    CCS_USER   = 7'h10,
    CCS_ERROR  = 7'h20,
    CCS_PULSE  = 7'h40
  } ccs_state_t;
endpackage

// ==== hdl/ccs_tmr_if.sv ====
// Carrier between the handshake controller and its microsecond timer.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface ccs_tmr_if;
  import ccs_pkg::*;
  logic            start;
  logic [US_W-1:0] limit_us;
  logic            done;
  modport ctrl (output start, output limit_us, input done);
  modport tmr  (input start, input limit_us, output done);
endinterface

// ==== hdl/ccs_timer.sv ====
// Microsecond interval timer with a one-cycle microsecond enable.
// Assumes limit_us is steady while the interval runs.
`timescale 1ns/1ps
module ccs_timer
  import ccs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  ccs_tmr_if.tmr    t
);
  logic [6:0]      div_q;
  logic [US_W-1:0] us_q;
  logic            us_tick;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  assign us_tick = (div_q == 7'(CYC_PER_US - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || t.start || us_tick) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // ----------------------------------------
  // Interval count
  // ----------------------------------------
  // Runs from reset, so the power-on interval needs no start pulse
  always_ff @(posedge clk_i) begin
    if (rst_i || t.start) begin
      us_q <= '0;
    end else if (us_tick && !t.done) begin
      us_q <= us_q + US_W'(1);
    end
  end

  assign t.done = (us_q >= t.limit_us);
endmodule

// ==== bench/ccs_host_model.sv ====
// Far-side host model: pull-ups, host pull-down and retry counting.
// Assumes device output enables are active low (low = pulling low).
`timescale 1ns/1ps
module ccs_host_model (
  input  wire logic  clk_i,
  input  wire logic  status_oe_n_i,
  input  wire logic  cc_oe_n_i,
  input  wire logic  pull_low_i,
  output logic       status_o,
  output logic       config_complete_o,
  output logic [7:0] retry_count_o
);
  // ----------------------------------------
  // Wire resolution and retry
  // ----------------------------------------
  logic status_q;

  // Pull-up gives high only when nobody pulls
  assign status_o          = status_oe_n_i & ~pull_low_i;
  assign config_complete_o = cc_oe_n_i;

  initial retry_count_o = 8'h00;
  initial status_q = 1'b1;

  // A release after a low starts a new attempt on our side
  always @(posedge clk_i) begin
    if (status_o && !status_q) begin
      retry_count_o <= retry_count_o + 8'h01;
    end
    status_q <= status_o;
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the configuration handshake controller.
// Assumes a host model resolving the open-drain wires.
`timescale 1ns/1ps
module testbench;
  import ccs_pkg::*;
  // ----------------------------------------
  // Stimulus and wiring
  // ----------------------------------------
  localparam int unsigned POR_US = 5; // Short power-on interval keeps runs brief
  logic       clk = 1'b0, rst = 1'b1, req_n = 1'b1, ce_n = 1'b0, jtag = 1'b0;
  logic       auto = 1'b0, dd = 1'b0, de = 1'b0, idn = 1'b0, pull = 1'b0;
  logic [2:0] scheme = 3'h5;
  logic       st, st_o, st_oe_n, cc, cc_o, cc_oe_n, io_float, cfg, user;
  logic [2:0] scheme_q;
  logic [7:0] retry;
  int         err_count = 0, checked = 0, n;

  always #5 clk = ~clk;

  ccs_ctrl #(.POR_US(POR_US)) u_dut (
    .clk_i(clk), .rst_i(rst), .scheme_select_i(scheme), .config_req_n_i(req_n),
    .chip_enable_n_i(ce_n), .jtag_mode_i(jtag), .auto_restart_i(auto),
    .data_done_i(dd), .data_error_i(de), .init_done_i(idn), .status_i(st),
    .status_o(st_o), .status_oe_n_o(st_oe_n), .config_complete_i(cc),
    .config_complete_o(cc_o), .config_complete_oe_n_o(cc_oe_n),
    .scheme_o(scheme_q), .io_float_o(io_float), .configuring_o(cfg),
    .user_mode_o(user));

  ccs_host_model u_host (
    .clk_i(clk), .status_oe_n_i(st_oe_n), .cc_oe_n_i(cc_oe_n),
    .pull_low_i(pull), .status_o(st), .config_complete_o(cc),
    .retry_count_o(retry));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic reconf();
    req_n = 1'b0;
    cyc(2);
    req_n = 1'b1;
    cyc(2);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_por();
    chk(st_oe_n, 1'b0);
    chk(io_float, 1'b1);
    chk({st_o, cc_o}, 2'h0);
    n = 0;
    while (st_oe_n === 1'b0 && n < 1000) begin
      n++;
      cyc(1);
    end
    chk(st_oe_n, 1'b1);
    chk(n >= POR_US * CYC_PER_US - 2 && n <= POR_US * CYC_PER_US + 2, 1'b1);
    cyc(2);
    chk(cfg, 1'b1);
    chk(cc, 1'b0);
    chk(scheme_q, 3'h5);
    $display("test por done");
  endtask

  task automatic t_normal();
    dd = 1'b1;
    cyc(1);
    dd = 1'b0;
    cyc(1);
    chk(cc, 1'b1);
    idn = 1'b1;
    cyc(1);
    idn = 1'b0;
    cyc(1);
    chk({user, io_float}, 2'h2);
    pull = 1'b1; // Host pull in user mode must be ignored
    cyc(3);
    pull = 1'b0;
    cyc(2);
    chk(user, 1'b1);
    $display("test normal done");
  endtask

  task automatic t_req();
    scheme = 3'h2;
    req_n = 1'b0;
    cyc(2);
    chk({io_float, user, cfg}, 3'h4);
    ce_n = 1'b1; // Chip enable high refuses the start
    req_n = 1'b1;
    cyc(3);
    chk(cfg, 1'b0);
    ce_n = 1'b0;
    cyc(2);
    chk(cfg, 1'b1);
    chk(scheme_q, 3'h2);
    $display("test request done");
  endtask

  task automatic t_err();
    pull = 1'b1;
    cyc(1);
    pull = 1'b0;
    cyc(2);
    chk({cfg, st_oe_n, st}, 3'h0);
    reconf();
    de = 1'b1;
    cyc(1);
    de = 1'b0;
    cyc(2);
    chk({cfg, st}, 2'h0);
    reconf();
    chk(cfg, 1'b1);
    dd = 1'b1;
    cyc(1);
    dd = 1'b0;
    pull = 1'b1; // Host pulls status low during initialisation
    cyc(1);
    pull = 1'b0;
    cyc(1);
    chk({cfg, st_oe_n, cc}, 3'h0);
    reconf();
    chk(cfg, 1'b1);
    $display("test error done");
  endtask

  task automatic t_pulse();
    logic [7:0] r0;
    r0 = retry;
    auto = 1'b1;
    de = 1'b1;
    cyc(1);
    de = 1'b0;
    n = 0;
    while (st === 1'b0 && n < 60000) begin
      n++;
      cyc(1);
    end
    chk(n >= PULSE_MIN_CYC && n <= PULSE_MAX_CYC, 1'b1);
    cyc(1);
    chk(cfg, 1'b1);
    chk(retry, r0 + 8'h01);
    $display("test pulse done");
  endtask

  task automatic t_jtag();
    jtag = 1'b1;
    req_n = 1'b0;
    scheme = 3'h7; // Strap moved mid attempt must not be taken
    cyc(3);
    chk(cfg, 1'b1);
    chk(scheme_q, 3'h2);
    req_n = 1'b1;
    jtag = 1'b0;
    cyc(2);
    $display("test jtag done");
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(3);
    rst = 1'b0;
    cyc(1);
    t_por();
    t_normal();
    t_req();
    t_err();
    t_pulse();
    t_jtag();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule
